// ==== core/atomiser_control.v ====
// Atomiser mode, frame, LED, calibration and colour control.
//
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "atomiser_defines.vh"
module atomiser_control #(
    parameter [15:0] BAUD_DIV = `BAUD_DIV,
    parameter [16:0] MS_CYCLES = `MS_CYCLES
) (
    input wire clk, // 100 MHz clock.
    input wire nrst, // Synchronous reset, active low.
    input wire rx, // Serial data from host.
    output wire tx, // Serial data to host.
    input wire [7:0] power_resistor_input, // Sensed resistance, 100 ohm units.
    input wire calibration_key_input, // Calibration key, low when pressed.
    input wire water_sense_input, // High when water is present.
    input wire detect_enable, // Water detection switch.
    input wire over_current, // Over-current fault level.
    input wire track_done, // Plate drive reports tracking locked.
    output reg status_led, // Status LED drive.
    output reg [7:0] red, // Red brightness.
    output reg [7:0] green, // Green brightness.
    output reg [7:0] blue, // Blue brightness.
    output reg [5:0] power_level, // 0 off, 1 to 32 power level.
    output reg atomise_on, // Plate drive enable.
    output reg tracking, // Frequency tracking running.
    output reg comm_mode, // High in communication mode.
    output reg asleep, // Sleep state.
    input wire [3:0] address, // Avalon byte address.
    input wire read, // Avalon read.
    input wire write, // Avalon write.
    input wire [31:0] writedata, // Avalon write data.
    output reg [31:0] readdata, // Avalon read data.
    output wire waitrequest // Avalon wait request.
);
    localparam [2:0] P_HEAD = 3'd0, P_T0 = 3'd1, P_T1 = 3'd2, P_LEN = 3'd3;
    localparam [2:0] P_CMD = 3'd4, P_DATA = 3'd5, P_CS = 3'd6;
    localparam [2:0] C_IDLE = 3'd0, C_RUN_E = 3'd1, C_DONE_E = 3'd2, C_RUN_F = 3'd3;
    localparam [2:0] C_OK = 3'd4, C_FAIL = 3'd5;

    wire [7:0] rx_data;
    wire rx_valid;
    wire tx_busy;
    reg tx_start;
    reg [7:0] tx_byte;
    uart_rx #(.DIV(BAUD_DIV)) u_rx (.clk(clk), .nrst(nrst), .rx(rx),
        .data(rx_data), .valid(rx_valid));
    uart_tx #(.DIV(BAUD_DIV)) u_tx (.clk(clk), .nrst(nrst), .start(tx_start),
        .data(tx_byte), .tx(tx), .busy(tx_busy));

    // Millisecond tick shared by all timers.
    reg [16:0] pre;
    wire ms = (pre == MS_CYCLES - 17'h0_0001);
    always @(posedge clk) begin
        if (!nrst || ms) begin
            pre <= 17'h0_0000;
        end else begin
            pre <= pre + 17'h0_0001;
        end
    end

    reg mode_done;
    wire water_ok = !detect_enable || water_sense_input;
    always @(posedge clk) begin
        if (!nrst) begin
            mode_done <= 1'b0;
            comm_mode <= 1'b1;
        end else if (!mode_done) begin
            mode_done <= 1'b1;
            comm_mode <= power_resistor_input > `RES_PRESENT;
        end else if (rx_valid) begin
            comm_mode <= 1'b1;
        end
    end

    // Frame receiver.
    reg [2:0] ps;
    reg [7:0] sum, len, cmd, d0, cnt;
    reg frame_ok, frame_end;
    always @(posedge clk) begin
        frame_end <= 1'b0;
        if (!nrst) begin
            ps <= P_HEAD;
            sum <= 8'h00;
            len <= 8'h00;
            cmd <= 8'h00;
            d0 <= 8'h00;
            cnt <= 8'h00;
            frame_ok <= 1'b0;
        end else if (rx_valid) begin
            sum <= sum + rx_data;
            case (ps)
                P_HEAD: begin
                    sum <= rx_data;
                    if (rx_data == `HEAD_BYTE) ps <= P_T0;
                end
                P_T0: ps <= (rx_data == `TYPE_HI) ? P_T1 : P_HEAD;
                P_T1: ps <= (rx_data == `TYPE_LO) ? P_LEN : P_HEAD;
                P_LEN: begin
                    len <= rx_data;
                    ps <= (rx_data != 8'h00 && rx_data <= 8'h05) ? P_CMD : P_HEAD;
                end
                P_CMD: begin
                    cmd <= rx_data;
                    cnt <= 8'h01;
                    ps <= (len == 8'h01) ? P_CS : P_DATA;
                end
                P_DATA: begin
                    if (cnt == 8'h01) d0 <= rx_data;
                    cnt <= cnt + 8'h01;
                    if (cnt + 8'h01 == len) ps <= P_CS;
                end
                P_CS: begin
                    frame_ok <= (rx_data == ~sum);
                    frame_end <= 1'b1;
                    ps <= P_HEAD;
                end
                default: ps <= P_HEAD;
            endcase
        end
    end

    // Reply transmitter; frames arriving during tracking get no answer.
    reg [2:0] tx_idx;
    reg tx_run;
    reg [7:0] tx_status;
    wire [7:0] tx_cs = ~(`HEAD_BYTE + `TYPE_HI + `TYPE_LO + 8'h01 + tx_status);
    always @* begin
        case (tx_idx)
            3'd0: tx_byte = `HEAD_BYTE;
            3'd1: tx_byte = `TYPE_HI;
            3'd2: tx_byte = `TYPE_LO;
            3'd3: tx_byte = 8'h01;
            3'd4: tx_byte = tx_status;
            default: tx_byte = tx_cs;
        endcase
    end
    always @(posedge clk) begin
        tx_start <= 1'b0;
        if (!nrst) begin
            tx_idx <= 3'd0;
            tx_run <= 1'b0;
            tx_status <= `ST_OK;
        end else if (frame_end && !tracking && !tx_run) begin
            tx_run <= 1'b1;
            tx_idx <= 3'd0;
            tx_status <= frame_ok ? `ST_OK : `ST_CSUM;
        end else if (tx_run && !tx_busy && !tx_start) begin
            if (tx_idx == 3'd6) begin
                tx_run <= 1'b0;
            end else begin
                tx_start <= 1'b1;
            end
        end else if (tx_start) begin
            tx_idx <= tx_idx + 3'd1;
        end
    end

    // Command execution, sleep and tracking.
    wire exec = frame_end && frame_ok && !tracking;
    reg tracked, track_fail, cal_cmd_e, cal_cmd_f;
    reg [15:0] trk_ms;
    reg [5:0] host_level;
    always @(posedge clk) begin
        cal_cmd_e <= 1'b0;
        cal_cmd_f <= 1'b0;
        if (!nrst) begin
            asleep <= 1'b1;
            tracking <= 1'b0;
            tracked <= 1'b0;
            track_fail <= 1'b0;
            trk_ms <= 16'h0000;
            host_level <= 6'h00;
        end else begin
            if (tracking) begin
                if (ms) trk_ms <= trk_ms + 16'h0001;
                if (track_done) begin
                    tracking <= 1'b0;
                end else if (trk_ms >= `MS_TRACK_MAX) begin
                    tracking <= 1'b0;
                    track_fail <= 1'b1;
                end
            end
            if (exec) begin
                if (cmd == `CMD_SLEEP) asleep <= 1'b1;
                else if (cmd != `CMD_STATUS) asleep <= 1'b0;
                if (cmd == `CMD_CAL) begin
                    cal_cmd_e <= (d0 == `CAL_EMPTY);
                    cal_cmd_f <= (d0 == `CAL_FULL);
                end
                if (cmd == `CMD_POWER && d0 <= `POWER_MAX) host_level <= d0[5:0];
                if (water_ok && ((cmd == `CMD_POWER && !tracked) || cmd == `CMD_TRACK)) begin
                    tracking <= 1'b1;
                    tracked <= 1'b1;
                    trk_ms <= 16'h0000;
                end
            end
        end
    end

    wire [7:0] res = power_resistor_input;
    wire [8:0] res_step = {1'b0, res - `RES_ON} * 9'd2 / 9'd3;
    always @(posedge clk) begin
        if (!nrst) begin
            power_level <= 6'h00;
            atomise_on <= 1'b0;
        end else if (!comm_mode) begin
            power_level <= (res < `RES_ON) ? 6'h00 : (res >= `RES_FULL) ? 6'h20 :
                (res_step[5:0] + 6'h01);
            atomise_on <= res >= `RES_ON && water_ok && !track_fail;
        end else begin
            power_level <= host_level;
            atomise_on <= host_level != 6'h00 && !asleep && water_ok && !tracking &&
                !track_fail && !over_current;
        end
    end

    // Water calibration sequence.
    reg [2:0] cs;
    reg [15:0] cal_ms;
    reg key_d;
    wire key_hit = key_d && !calibration_key_input;
    always @(posedge clk) begin
        if (!nrst) begin
            cs <= C_IDLE;
            cal_ms <= 16'h0000;
            key_d <= 1'b1;
        end else begin
            key_d <= calibration_key_input;
            if (ms) cal_ms <= cal_ms + 16'h0001;
            case (cs)
                C_IDLE, C_OK: if (key_hit || cal_cmd_e) begin
                    cs <= C_RUN_E;
                    cal_ms <= 16'h0000;
                end
                C_RUN_E: if (cal_ms >= `MS_CAL_RUN) cs <= C_DONE_E;
                C_DONE_E: if (key_hit || cal_cmd_f) begin
                    cs <= C_RUN_F;
                    cal_ms <= 16'h0000;
                end
                C_RUN_F: if (cal_ms >= `MS_CAL_RUN) cs <= water_sense_input ? C_OK : C_FAIL;
                C_FAIL: cs <= C_FAIL;
                default: cs <= C_IDLE;
            endcase
        end
    end

    // Status LED pattern selection, highest priority first.
    reg [15:0] on_ms, off_ms, led_ms;
    reg steady, dark;
    always @* begin
        on_ms = `MS_200;
        off_ms = `MS_200;
        steady = 1'b0;
        dark = 1'b0;
        if (track_fail || over_current || cs == C_FAIL) begin
            on_ms = `MS_200;
        end else if (cs == C_RUN_E || cs == C_RUN_F) begin
            off_ms = `MS_1S;
        end else if (cs == C_DONE_E) begin
            on_ms = `MS_100;
            off_ms = `MS_1S;
        end else if (cs == C_OK) begin
            steady = 1'b1;
        end else if (!detect_enable) begin
            on_ms = `MS_STEADY_ON;
            off_ms = `MS_1S;
            dark = !water_sense_input;
        end else if (!water_sense_input) begin
            on_ms = `MS_1S;
            off_ms = `MS_1S;
        end else begin
            steady = 1'b1;
        end
    end
    always @(posedge clk) begin
        if (!nrst) begin
            led_ms <= 16'h0000;
            status_led <= 1'b0;
        end else begin
            if (ms) led_ms <= (led_ms + 16'h0001 >= on_ms + off_ms) ? 16'h0000 :
                led_ms + 16'h0001;
            status_led <= steady || (!dark && led_ms < on_ms);
        end
    end

    // Colour cycle: six fades, each one sixth of the period.
    reg [16:0] period;
    reg [2:0] phase;
    reg [16:0] seg_ms, acc;
    reg [7:0] ramp;
    wire [16:0] seg_len = period / 17'd6;
    always @(posedge clk) begin
        if (!nrst) begin
            red <= 8'hFF;
            green <= 8'h00;
            blue <= 8'h00;
            phase <= 3'd0;
            seg_ms <= 17'h0_0000;
            acc <= 17'h0_0000;
            ramp <= 8'h00;
        end else if (ms) begin
            if (seg_ms + 17'h0_0001 >= seg_len) begin
                seg_ms <= 17'h0_0000;
                acc <= 17'h0_0000;
                ramp <= 8'h00;
                phase <= (phase == 3'd5) ? 3'd0 : phase + 3'd1;
            end else begin
                seg_ms <= seg_ms + 17'h0_0001;
                if (acc + 17'h0_0100 >= seg_len) begin
                    acc <= acc + 17'h0_0100 - seg_len;
                    ramp <= (ramp == 8'hFF) ? 8'hFF : ramp + 8'h01;
                end else begin
                    acc <= acc + 17'h0_0100;
                end
            end
            case (phase)
                3'd0: green <= ramp;
                3'd1: red <= ~ramp;
                3'd2: blue <= ramp;
                3'd3: green <= ~ramp;
                3'd4: red <= ramp;
                default: blue <= ~ramp;
            endcase
        end
    end

    // Avalon slave: one wait cycle on every access.
    reg bus_ack;
    assign waitrequest = (read || write) && !bus_ack;
    always @(posedge clk) begin
        if (!nrst) begin
            bus_ack <= 1'b0;
            readdata <= 32'h0000_0000;
            period <= `PERIOD_DEF;
        end else begin
            bus_ack <= (read || write) && !bus_ack;
            if (read && !bus_ack) begin
                case (address)
                    `ADDR_PERIOD: readdata <= {15'h0000, period};
                    `ADDR_STATUS: readdata <= {20'h0_0000, track_fail, cs, tracked,
                        tracking, asleep, comm_mode, atomise_on, status_led,
                        water_sense_input, detect_enable};
                    `ADDR_POWER: readdata <= {26'h000_0000, power_level};
                    default: readdata <= 32'h0000_0000;
                endcase
            end
            if (write && bus_ack && address == `ADDR_PERIOD) begin
                period <= (writedata[16:0] < `PERIOD_MIN || writedata[31:17] != 15'h0000) ?
                    ((writedata[31:17] != 15'h0000) ? `PERIOD_MAX : `PERIOD_MIN) :
                    (writedata[16:0] > `PERIOD_MAX) ? `PERIOD_MAX : writedata[16:0];
            end
        end
    end
endmodule

// ==== core/atomiser_defines.vh ====
// Constants for the atomiser control logic.
`ifndef ATOMISER_DEFINES_VH
`define ATOMISER_DEFINES_VH
`define CLK_HZ 100000000
`define BAUD_RATE 9600
`define BAUD_DIV 16'h28B0
`define MS_CYCLES 17'h1_86A0
`define HEAD_BYTE 8'h55
// Module type bytes; the values are arbitrary.
`define TYPE_HI 8'hA5
`define TYPE_LO 8'h5A
`define ST_OK 8'h00
`define ST_CSUM 8'h40
`define CMD_CAL 8'h02
`define CMD_POWER 8'h03
`define CMD_SLEEP 8'h10
`define CMD_STATUS 8'h11
`define CMD_TRACK 8'h12
`define CAL_EMPTY 8'h01
`define CAL_FULL 8'h02
`define POWER_MAX 8'h20
`define RES_ON 8'h12
`define RES_FULL 8'h42
`define RES_PRESENT 8'h64
`define MS_STEADY_ON 16'h1388
`define MS_1S 16'h03E8
`define MS_200 16'h00C8
`define MS_100 16'h0064
`define MS_TRACK_MAX 16'h0C80
`define MS_CAL_RUN 16'h03E8
`define PERIOD_MIN 17'h0_0258
`define PERIOD_MAX 17'h1_01D0
`define PERIOD_DEF 17'h0_2EE0
`define ADDR_PERIOD 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_POWER 4'h8
`endif

// ==== core/uart_rx.v ====
// Serial receiver, 8 data bits, 1 stop bit, no parity.
`timescale 1ns/1ps
module uart_rx #(parameter [15:0] DIV = 16'h28B0) (
    input wire clk, // System clock.
    input wire nrst, // Synchronous reset, active low.
    input wire rx, // Serial line in.
    output reg [7:0] data, // Received byte.
    output reg valid // One-cycle pulse per byte.
);
    reg [15:0] cnt;
    reg [3:0] bitn;
    reg busy;
    always @(posedge clk) begin
        valid <= 1'b0;
        if (!nrst) begin
            cnt <= 16'h0000;
            bitn <= 4'h0;
            busy <= 1'b0;
            data <= 8'h00;
        end else if (!busy) begin
            if (!rx) begin
                busy <= 1'b1;
                cnt <= {1'b0, DIV[15:1]};
                bitn <= 4'h0;
            end
        end else if (cnt != 16'h0000) begin
            cnt <= cnt - 16'h0001;
        end else begin
            cnt <= DIV - 16'h0001;
            bitn <= bitn + 4'h1;
            if (bitn == 4'h0 && rx) begin
                busy <= 1'b0;
            end else if (bitn == 4'h9) begin
                busy <= 1'b0;
                valid <= rx;
            end else if (bitn != 4'h0) begin
                data <= {rx, data[7:1]};
            end
        end
    end
endmodule

// ==== core/uart_tx.v ====
// Serial transmitter, 8 data bits, 1 stop bit, no parity.
`timescale 1ns/1ps
module uart_tx #(parameter [15:0] DIV = 16'h28B0) (
    input wire clk, // System clock.
    input wire nrst, // Synchronous reset, active low.
    input wire start, // Pulse to send a byte.
    input wire [7:0] data, // Byte to send.
    output reg tx, // Serial line out.
    output wire busy // High while a byte is sent.
);
    reg [15:0] cnt;
    reg [3:0] bitn;
    reg [8:0] sh;
    reg run;
    assign busy = run;
    always @(posedge clk) begin
        if (!nrst) begin
            cnt <= 16'h0000;
            bitn <= 4'h0;
            sh <= 9'h1FF;
            run <= 1'b0;
            tx <= 1'b1;
        end else if (!run) begin
            if (start) begin
                run <= 1'b1;
                sh <= {1'b1, data};
                tx <= 1'b0;
                cnt <= DIV - 16'h0001;
                bitn <= 4'h0;
            end
        end else if (cnt != 16'h0000) begin
            cnt <= cnt - 16'h0001;
        end else if (bitn == 4'h9) begin
            run <= 1'b0;
        end else begin
            cnt <= DIV - 16'h0001;
            bitn <= bitn + 4'h1;
            tx <= sh[0];
            sh <= {1'b1, sh[8:1]};
        end
    end
endmodule

// ==== test/atomiser_control_asserts.sv ====
// Port checker for the atomiser control block.
`timescale 1ns/1ps
`include "atomiser_defines.vh"
module atomiser_control_asserts #(parameter [15:0] BAUD_DIV = 16'd16) (
    input wire clk, // Clock.
    input wire nrst, // Reset.
    input wire rx, // Host line.
    input wire tx, // Reply line.
    input wire [7:0] red, // Red.
    input wire [7:0] green, // Green.
    input wire [7:0] blue, // Blue.
    input wire status_led, // LED.
    input wire [5:0] power_level, // Level.
    input wire atomise_on, // Plate on.
    input wire comm_mode, // Mode.
    input wire asleep, // Sleep.
    input wire [3:0] address, // Address.
    input wire read, // Read.
    input wire write, // Write.
    input wire [31:0] readdata, // Read data.
    input wire waitrequest // Wait.
);
    reg was_rst;
    reg last_tx;
    reg [15:0] run;
    // Run counts samples since the serial output last changed.
    always @(posedge clk) begin
        was_rst <= !nrst;
        last_tx <= tx;
        if (!nrst)
            run <= 16'hFFFF;
        else if (tx != last_tx)
            run <= 16'h0000;
        else if (run != 16'hFFFF)
            run <= run + 16'h0001;
    end
    a_reset_values:
        assert property (@(posedge clk) was_rst |-> tx && red == 8'hFF && green == 8'h00
            && blue == 8'h00 && power_level == 6'h00 && comm_mode && asleep && !status_led)
        else $error("reset values wrong");
    a_bit_time:
        assert property (@(posedge clk) disable iff (!nrst)
            $changed(tx) |-> run >= BAUD_DIV - 16'h0001)
        else $error("serial bit too short");
    a_reply_after_frame:
        assert property (@(posedge clk) disable iff (!nrst)
            $fell(tx) |-> comm_mode && rx && $past(rx, 4))
        else $error("reply started during host traffic");
    a_mode_sticky:
        assert property (@(posedge clk) disable iff (!nrst) $fell(comm_mode) |-> !$past(nrst, 2))
        else $error("mode left communication");
    a_level_max:
        assert property (@(posedge clk) disable iff (!nrst) power_level <= 6'h20)
        else $error("power level above range");
    a_read_wait:
        assert property (@(posedge clk) disable iff (!nrst) $rose(read) |-> waitrequest ##1 !waitrequest)
        else $error("read wait not one cycle");
    a_write_wait:
        assert property (@(posedge clk) disable iff (!nrst) $rose(write) |-> waitrequest ##1 !waitrequest)
        else $error("write wait not one cycle");
    a_period_clamp:
        assert property (@(posedge clk) disable iff (!nrst) read && !waitrequest && address == 4'h0
            |-> readdata[16:0] >= `PERIOD_MIN && readdata[16:0] <= `PERIOD_MAX && readdata[31:17] == 0)
        else $error("period out of range");
    a_power_read:
        assert property (@(posedge clk) disable iff (!nrst) read && !waitrequest && address == 4'h8
            |-> readdata == {26'h000_0000, power_level})
        else $error("power read mismatch");
    a_status_read:
        assert property (@(posedge clk) disable iff (!nrst) read && !waitrequest && address == 4'h4
            |-> readdata[5:3] == {asleep, comm_mode, atomise_on})
        else $error("status read mismatch");
    a_unmapped_zero:
        assert property (@(posedge clk) disable iff (!nrst) read && !waitrequest && address == 4'hC
            |-> readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule
bind atomiser_control atomiser_control_asserts #(.BAUD_DIV(BAUD_DIV)) chk (.clk(clk), .nrst(nrst),
    .rx(rx), .tx(tx), .red(red), .green(green), .blue(blue), .status_led(status_led),
    .power_level(power_level), .atomise_on(atomise_on), .comm_mode(comm_mode), .asleep(asleep),
    .address(address), .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest));

// ==== test/host_uart_model.sv ====
// Host side serial model: sends bytes and collects replies.
`timescale 1ns/1ps
module host_uart_model #(parameter [15:0] DIV = 16'd16) (
    input wire clk, // Clock.
    output logic rx, // To device.
    input wire tx // From device.
);
    logic [7:0] got [$];
    logic [7:0] sh;
    initial rx = 1'b1;
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            rx <= f[i];
            repeat (DIV - 1) @(posedge clk);
        end
    endtask
    initial begin
        forever begin
            @(negedge tx);
            repeat (DIV / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (DIV) @(posedge clk);
                sh[i] = tx;
            end
            repeat (DIV) @(posedge clk);
            got.push_back(sh);
        end
    end
endmodule

// ==== test/atomiser_control_tb.sv ====
// Self-checking bench for the atomiser control block.
`timescale 1ns/1ps
`include "atomiser_defines.vh"
module atomiser_control_tb;
    localparam [15:0] DIV = 16'd16;
    localparam [16:0] MSC = 17'd20;
    logic clk, nrst, key, water, det, oc, tdone, read, write;
    logic [7:0] res, p;
    logic [3:0] address;
    logic [31:0] writedata, rd;
    logic [7:0] rv [5] = '{8'd16, 8'd18, 8'd42, 8'd66, 8'd90};
    logic [5:0] lv [5] = '{6'd0, 6'd1, 6'd17, 6'd32, 6'd32};
    wire rx, tx, status_led, atomise_on, tracking, comm_mode, asleep, waitrequest;
    wire [7:0] red, green, blue;
    wire [5:0] power_level;
    wire [31:0] readdata;
    int num_errors, samples_checked, cycles, on, off;
    atomiser_control #(.BAUD_DIV(DIV), .MS_CYCLES(MSC)) dut (.clk(clk), .nrst(nrst), .rx(rx),
        .tx(tx), .power_resistor_input(res), .calibration_key_input(key),
        .water_sense_input(water), .detect_enable(det), .over_current(oc), .track_done(tdone),
        .status_led(status_led), .red(red), .green(green), .blue(blue),
        .power_level(power_level), .atomise_on(atomise_on), .tracking(tracking),
        .comm_mode(comm_mode), .asleep(asleep), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
    host_uart_model #(.DIV(DIV)) host (.clk(clk), .rx(rx), .tx(tx));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic report_and_stop();
        if (num_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            num_errors = num_errors + 1;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %0t %s", $time, what);
            num_errors++;
        end
    endtask
    task automatic reset(input logic [7:0] r);
        @(posedge clk);
        nrst <= 1'b0;
        res <= r;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0);
        chk(32'(n), 32'd2, "bus answer");
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic frame(input logic [7:0] cmd, input logic [7:0] d0, input int nd, input logic bad);
        logic [7:0] q [$];
        logic [7:0] s;
        q = {`HEAD_BYTE, `TYPE_HI, `TYPE_LO, 8'(nd + 1), cmd};
        if (nd > 0)
            q.push_back(d0);
        s = 8'h00;
        foreach (q[i]) begin
            host.send_byte(q[i]);
            s = s + q[i];
        end
        // complemented sum, or a broken one
        host.send_byte(bad ? s : ~s);
    endtask
    task automatic expect_reply(input logic [7:0] st, input logic none);
        logic [7:0] e [6];
        int n;
        e = '{`HEAD_BYTE, `TYPE_HI, `TYPE_LO, 8'h01, st, 8'h00};
        e[5] = ~(e[0] + e[1] + e[2] + e[3] + e[4]);
        for (n = 0; n < 3000 && host.got.size() < 6; n++)
            @(posedge clk);
        chk(32'(host.got.size()), none ? 32'd0 : 32'd6, "reply length");
        for (int i = 0; i < host.got.size() && i < 6; i++)
            chk(32'(host.got[i]), 32'(e[i]), "reply byte");
        host.got.delete();
        // idle gap before the next frame
        repeat (220) @(posedge clk);
    endtask
    initial begin
        nrst = 1'b0;
        res = 8'hC8;
        key = 1'b1;
        water = 1'b1;
        det = 1'b1;
        oc = 1'b0;
        tdone = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 4'h0;
        writedata = 32'h0000_0000;
        num_errors = 0;
        samples_checked = 0;
        cycles = 0;
        reset(8'hC8);
        chk(32'({comm_mode, asleep}), 32'd3, "comm mode asleep");
        bus(1'b0, `ADDR_PERIOD, 32'h0000_0000);
        chk(rd, 32'h0000_2EE0, "period default");
        bus(1'b1, `ADDR_PERIOD, 32'h0000_01F4);
        bus(1'b0, `ADDR_PERIOD, 32'h0000_0000);
        chk(rd, 32'h0000_0258, "period low clamp");
        bus(1'b1, `ADDR_PERIOD, 32'h0001_1170);
        bus(1'b0, `ADDR_PERIOD, 32'h0000_0000);
        chk(rd, 32'h0001_01D0, "period high clamp");
        bus(1'b1, 4'hC, 32'h0000_0001);
        bus(1'b0, 4'hC, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "unmapped read");
        host.send_byte(8'h13);
        frame(`CMD_POWER, 8'h05, 1, 1'b1);
        expect_reply(`ST_CSUM, 1'b0);
        chk(32'({asleep, power_level}), 32'h0000_0040, "bad frame ignored");
        frame(`CMD_SLEEP, 8'h00, 0, 1'b0);
        expect_reply(`ST_OK, 1'b0);
        frame(`CMD_STATUS, 8'h00, 0, 1'b0);
        expect_reply(`ST_OK, 1'b0);
        chk(32'(asleep), 32'd1, "still asleep");
        frame(`CMD_POWER, 8'h05, 1, 1'b0);
        expect_reply(`ST_OK, 1'b0);
        chk(32'({asleep, tracking}), 32'd1, "awake and tracking");
        frame(`CMD_POWER, 8'h20, 1, 1'b0);
        expect_reply(`ST_OK, 1'b1);
        @(posedge clk);
        tdone <= 1'b1;
        @(posedge clk);
        tdone <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'({atomise_on, tracking, power_level}), 32'h0000_0085, "tracking ended");
        frame(`CMD_POWER, 8'h20, 1, 1'b0);
        expect_reply(`ST_OK, 1'b0);
        bus(1'b0, `ADDR_POWER, 32'h0000_0000);
        chk(rd, 32'h0000_0020, "level max");
        frame(`CMD_POWER, 8'h00, 1, 1'b0);
        expect_reply(`ST_OK, 1'b0);
        chk(32'({atomise_on, power_level}), 32'd0, "level off");
        frame(`CMD_CAL, `CAL_EMPTY, 1, 1'b0);
        expect_reply(`ST_OK, 1'b0);
        bus(1'b0, `ADDR_STATUS, 32'h0000_0000);
        chk(32'(rd[10:4]), 32'h0000_0019, "status awake calibrating");
        @(posedge clk);
        oc <= 1'b1;
        for (int n = 0; n < 9000 && status_led !== 1'b0; n++) @(posedge clk);
        for (int n = 0; n < 9000 && status_led !== 1'b1; n++) @(posedge clk);
        for (on = 0; on < 9000 && status_led === 1'b1; on++) @(posedge clk);
        for (off = 0; off < 9000 && status_led === 1'b0; off++) @(posedge clk);
        chk(32'(on >= 3999 && on <= 4001 && off >= 3999 && off <= 4001), 32'd1, "fault blink");
        oc <= 1'b0;
        reset(8'd66);
        chk(32'(comm_mode), 32'd0, "stand-alone");
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            res <= rv[i];
            repeat (50) @(posedge clk);
            chk(32'(power_level), 32'(lv[i]), "resistor level");
        end
        frame(`CMD_SLEEP, 8'h00, 0, 1'b0);
        expect_reply(`ST_OK, 1'b0);
        chk(32'(comm_mode), 32'd1, "switched mode");
        p = 8'(power_level);
        res <= 8'd18;
        repeat (50) @(posedge clk);
        chk(32'(power_level), 32'(p), "resistor ignored");
        report_and_stop();
    end
endmodule
